// [core/ietc_pkg.sv]
package ietc_pkg;
    // structure of the controller
    localparam int NODE_COUNT = 96;
    localparam int CHAN_COUNT = 8;
    localparam int FAST_COUNT = 4;
    localparam int ALT_COUNT = 6;
    localparam int SHARED_COUNT = 14;
    localparam int ADDR_W = 24;
    localparam int COUNT_W = 8;
    localparam int LEVEL_W = 4;
    localparam int TRAP_W = 7;
    localparam int CHAN_W = 3;
    localparam int IDX_W = 7;
    // trap numbering and the end-of-transfer node
    localparam logic [6:0] FIRST_TRAP = 7'h10;
    localparam logic [6:0] END_NODE_IDX = 7'h5f;
    localparam int VEC_BASE_SHIFT = 2;
    // response time budget in clocks, with and without the jump cache
    localparam int RESP_CLK_CACHE = 7;
    localparam int RESP_CLK_NOCACHE = 11;
    // apb byte offsets
    localparam logic [11:0] NODE_LIMIT = 12'h180;
    localparam logic [11:0] CHAN_BASE = 12'h200;
    localparam logic [11:0] CHAN_LIMIT = 12'h280;
    localparam logic [1:0] CH_SRC_SEL = 2'h0;
    localparam logic [1:0] CH_DST_SEL = 2'h1;
    localparam logic [1:0] CH_CTL_SEL = 2'h2;
    localparam logic [11:0] EDGE_OFF = 12'h300;
    localparam logic [11:0] VSEG_OFF = 12'h304;
    localparam logic [11:0] CPUCTL_OFF = 12'h308;
    localparam logic [11:0] STAT_OFF = 12'h30c;
    localparam logic [11:0] TRAP_OFF = 12'h310;
    // node control fields
    localparam int NF_REQ = 0;
    localparam int NF_EN = 1;
    localparam int NF_LVL = 2;
    localparam int NF_XFER = 6;
    localparam int NF_CHAN = 7;
    localparam int NF_ALT = 10;
    // channel control fields
    localparam int CF_CNT = 0;
    localparam int CF_CONT = 8;
    localparam int CF_INCS = 9;
    localparam int CF_INCD = 10;
    localparam int CF_BYTE = 11;
    localparam int CF_END = 12;
    // values after reset
    localparam logic [7:0] VSEG_RST = 8'h00;
    localparam logic [1:0] SPACING_RST = 2'h0;
    // pointer steps
    localparam logic [23:0] BYTE_STEP = 24'h000001;
    localparam logic [23:0] WORD_STEP = 24'h000002;
    // fast pin edge selection, bit 0 rising, bit 1 falling
    typedef enum logic [1:0] {
        IETC_EDGE_NONE = 2'b00,
        IETC_EDGE_RISE = 2'b01,
        IETC_EDGE_FALL = 2'b10,
        IETC_EDGE_BOTH = 2'b11
    } ietc_edge_e;
    typedef enum logic {
        IETC_IDLE = 1'b0,
        IETC_OFFER = 1'b1
    } ietc_state_e;
endpackage : ietc_pkg

// [core/ietc_top.sv]
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - Offers an accepted request to the CPU well inside 7 or 11 clocks.
// - Each node chooses standard interrupt or event transfer service.
// - Standard service offers the requesting node's own vector to the CPU.
// - Event transfer takes exactly one stolen cycle, no vectoring.
// - Transfer moves a byte or word, then bumps source, destination or both.
// - Counter drops by one per transfer, held in continuous mode.
// - Counter reaching zero turns the source into a standard interrupt.
// - Eight independent transfer channels triggered by node requests.
// - Every node has request, enable and priority bits in its own register.
// - Priority field selects one of sixteen levels.
// - Only a node at a strictly higher level than the CPU's may be offered.
// - Each node owns a dedicated vector location.
// - Fast pins detect rising, falling or both edges as programmed.
// - A software trap number vectors to its own entry.
// - Software setting a request bit acts like a hardware request.
// - Vector offset is trap number times four at default spacing, first node trap 10h.
// - Nodes for channels 16 to 29 share a second source; 30, 31 do not.
// - Fixed node order follows consecutive trap numbers up to 6fh.
// - Vector segment register and spacing field, spacing default four bytes.
// - End-of-transfer node at trap 6fh can flag finished channels.
module ietc_top
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request sources
    input wire logic [ietc_pkg::NODE_COUNT-1:0] periphReq,
    input wire logic [ietc_pkg::ALT_COUNT-1:0] altReq,
    input wire logic [ietc_pkg::FAST_COUNT-1:0] fastPin,
    // cpu side
    input wire logic [ietc_pkg::LEVEL_W-1:0] cpuLevel,
    input wire logic cpuAck,
    output logic irqReq,
    output logic irqIsTrap,
    output logic [ietc_pkg::ADDR_W-1:0] irqVector,
    output logic [ietc_pkg::LEVEL_W-1:0] irqLevel,
    output logic [ietc_pkg::TRAP_W-1:0] irqTrapNum,
    // stolen-cycle move command
    output logic stealValid,
    output logic [ietc_pkg::ADDR_W-1:0] stealSrc,
    output logic [ietc_pkg::ADDR_W-1:0] stealDst,
    output logic stealByte
);
    import ietc_pkg::*;

    typedef struct packed {
        ietc_state_e state;
        logic [NODE_COUNT-1:0] req;
        logic [NODE_COUNT-1:0] en;
        logic [NODE_COUNT-1:0] xferMode;
        logic [NODE_COUNT-1:0] altSel;
        logic [NODE_COUNT-1:0][LEVEL_W-1:0] level;
        logic [NODE_COUNT-1:0][CHAN_W-1:0] chan;
        logic [CHAN_COUNT-1:0][ADDR_W-1:0] src;
        logic [CHAN_COUNT-1:0][ADDR_W-1:0] dst;
        logic [CHAN_COUNT-1:0][COUNT_W-1:0] count;
        logic [CHAN_COUNT-1:0] cont;
        logic [CHAN_COUNT-1:0] incSrc;
        logic [CHAN_COUNT-1:0] incDst;
        logic [CHAN_COUNT-1:0] byteMode;
        logic [CHAN_COUNT-1:0] endNode;
        logic [FAST_COUNT-1:0][2:0] pinSync;
        logic [FAST_COUNT-1:0] pinLast;
        logic [FAST_COUNT-1:0][1:0] edgeSel;
        logic [7:0] vector_segment_register;
        logic [1:0] spacing;
        logic trapPend;
        logic [TRAP_W-1:0] trapNum;
        logic [IDX_W-1:0] offerNode;
        logic offerIsTrap;
        logic [ADDR_W-1:0] irqVector;
        logic [LEVEL_W-1:0] irqLevel;
        logic [TRAP_W-1:0] irqTrapNum;
        logic stealValid;
        logic [ADDR_W-1:0] stealSrc;
        logic [ADDR_W-1:0] stealDst;
        logic stealByte;
        logic [CHAN_W-1:0] stealChan;
        logic [31:0] prdata;
        logic pslverr;
    } ietc_state_s;

    ietc_state_s state_reg;
    ietc_state_s state_next;
    logic [1:0] rstPipe_reg;
    logic rstN;
    logic [FAST_COUNT-1:0] extHit;
    logic [NODE_COUNT-1:0] hwSet;
    logic found;
    logic [IDX_W-1:0] bestIdx;
    logic [LEVEL_W-1:0] bestLvl;
    logic [CHAN_W-1:0] bestChan;
    logic bestXfer;
    logic [IDX_W-1:0] regIdx;
    logic [CHAN_W-1:0] chIdx;
    logic hitNode;
    logic hitChan;
    logic mapped;
    logic apbWrite;
    logic [31:0] rdata;

    // vector address: segment on top, trap scaled by the spacing field below
    function automatic logic [ADDR_W-1:0] vecAddr(input logic [TRAP_W-1:0] t,
                                                  input logic [1:0] sp,
                                                  input logic [7:0] seg);
        logic [15:0] off;
        off = 16'({9'h000, t} << (VEC_BASE_SHIFT + int'(sp)));
        vecAddr = {seg, off};
    endfunction : vecAddr

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rstPipe_reg <= 2'b00;
        else
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
    assign rstN = rstPipe_reg[1];

    // all controller state lives in one register
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // apb decode on the presented address
    assign regIdx = paddr[8:2];
    assign chIdx = paddr[6:4];
    assign hitNode = paddr < NODE_LIMIT;
    assign hitChan = (paddr >= CHAN_BASE) && (paddr < CHAN_LIMIT) && (paddr[3:2] != 2'h3);
    assign mapped = hitNode || hitChan || paddr == EDGE_OFF || paddr == VSEG_OFF
                    || paddr == CPUCTL_OFF || paddr == STAT_OFF || paddr == TRAP_OFF;
    assign apbWrite = psel && penable && pwrite && mapped;

    // read mux; sampled in the setup cycle so prdata is a flop at access
    always_comb
    begin
        rdata = '0;
        if (hitNode)
            rdata = {21'h000000, state_reg.altSel[regIdx], state_reg.chan[regIdx],
                     state_reg.xferMode[regIdx], state_reg.level[regIdx],
                     state_reg.en[regIdx], state_reg.req[regIdx]};
        else if (hitChan)
        begin
            unique case (paddr[3:2])
                CH_SRC_SEL: rdata = {8'h00, state_reg.src[chIdx]};
                CH_DST_SEL: rdata = {8'h00, state_reg.dst[chIdx]};
                default: rdata = {19'h00000, state_reg.endNode[chIdx],
                                  state_reg.byteMode[chIdx], state_reg.incDst[chIdx],
                                  state_reg.incSrc[chIdx], state_reg.cont[chIdx],
                                  state_reg.count[chIdx]};
            endcase
        end
        else if (paddr == EDGE_OFF)
            rdata = {24'h000000, state_reg.edgeSel};
        else if (paddr == VSEG_OFF)
            rdata = {24'h000000, state_reg.vector_segment_register};
        else if (paddr == CPUCTL_OFF)
            rdata = {30'h00000000, state_reg.spacing};
        else if (paddr == STAT_OFF)
            rdata = {8'h00, 1'b0, state_reg.offerNode, 1'b0, state_reg.trapNum,
                     state_reg.trapPend, state_reg.offerIsTrap,
                     state_reg.irqLevel, 1'b0, state_reg.state};
    end

    // pin edge detection; only the second and third flops are inspected
    always_comb
    begin
        extHit = '0;
        for (int k = 0; k < FAST_COUNT; k++)
        begin
            if (state_reg.pinSync[k][1] == state_reg.pinSync[k][2]
                && state_reg.pinSync[k][2] != state_reg.pinLast[k])
                extHit[k] = state_reg.pinSync[k][2] ? state_reg.edgeSel[k][0]
                                                    : state_reg.edgeSel[k][1];
        end
    end

    // hardware set sources, shared nodes take the alternate when selected
    always_comb
    begin
        hwSet = periphReq;
        hwSet[SHARED_COUNT-1:0] = periphReq[SHARED_COUNT-1:0]
            | (state_reg.altSel[SHARED_COUNT-1:0]
               & {altReq[5:4], extHit, altReq[3:0], extHit});
    end

    // arbitration: strict greater keeps the lowest index on a tie
    always_comb
    begin
        found = 1'b0;
        bestIdx = '0;
        bestLvl = '0;
        for (int i = 0; i < NODE_COUNT; i++)
        begin
            if (state_reg.req[i] && state_reg.en[i] && state_reg.level[i] > cpuLevel
                && (!found || state_reg.level[i] > bestLvl))
            begin
                found = 1'b1;
                bestIdx = IDX_W'(i);
                bestLvl = state_reg.level[i];
            end
        end
        bestChan = state_reg.chan[bestIdx];
        // an exhausted channel hands its source back to standard service
        bestXfer = state_reg.xferMode[bestIdx]
                   && (state_reg.cont[bestChan] || state_reg.count[bestChan] != '0);
    end

    // next state: service first, software writes next, hardware sets last
    always_comb
    begin
        state_next = state_reg;
        state_next.stealValid = 1'b0;
        for (int k = 0; k < FAST_COUNT; k++)
        begin
            state_next.pinSync[k] = {state_reg.pinSync[k][1:0], fastPin[k]};
            if (state_reg.pinSync[k][1] == state_reg.pinSync[k][2])
                state_next.pinLast[k] = state_reg.pinSync[k][2];
        end
        if (psel && !penable)
        begin
            state_next.prdata = rdata;
            state_next.pslverr = !mapped;
        end
        unique case (state_reg.state)
            IETC_IDLE:
            begin
                if (state_reg.trapPend)
                begin
                    state_next.state = IETC_OFFER;
                    state_next.offerIsTrap = 1'b1;
                    state_next.irqTrapNum = state_reg.trapNum;
                    state_next.irqLevel = cpuLevel;
                    state_next.irqVector = vecAddr(state_reg.trapNum, state_reg.spacing,
                                                   state_reg.vector_segment_register);
                end
                else if (found && bestXfer)
                begin
                    // one stolen cycle: move command out, pointers and count updated
                    state_next.stealValid = 1'b1;
                    state_next.stealSrc = state_reg.src[bestChan];
                    state_next.stealDst = state_reg.dst[bestChan];
                    state_next.stealByte = state_reg.byteMode[bestChan];
                    state_next.stealChan = bestChan;
                    if (state_reg.incSrc[bestChan])
                        state_next.src[bestChan] = state_reg.src[bestChan]
                            + (state_reg.byteMode[bestChan] ? BYTE_STEP : WORD_STEP);
                    if (state_reg.incDst[bestChan])
                        state_next.dst[bestChan] = state_reg.dst[bestChan]
                            + (state_reg.byteMode[bestChan] ? BYTE_STEP : WORD_STEP);
                    state_next.req[bestIdx] = 1'b0;
                    if (!state_reg.cont[bestChan])
                    begin
                        state_next.count[bestChan] = state_reg.count[bestChan] - 8'h01;
                        // last transfer: source stays requested unless the end node takes it
                        if (state_reg.count[bestChan] == 8'h01 && !state_reg.endNode[bestChan])
                            state_next.req[bestIdx] = 1'b1;
                    end
                end
                else if (found)
                begin
                    state_next.state = IETC_OFFER;
                    state_next.offerIsTrap = 1'b0;
                    state_next.offerNode = bestIdx;
                    state_next.irqLevel = bestLvl;
                    state_next.irqTrapNum = TRAP_W'(FIRST_TRAP + bestIdx);
                    state_next.irqVector = vecAddr(TRAP_W'(FIRST_TRAP + bestIdx),
                                                   state_reg.spacing, state_reg.vector_segment_register);
                end
            end
            IETC_OFFER:
            begin
                if (state_reg.offerIsTrap)
                begin
                    if (cpuAck)
                    begin
                        state_next.trapPend = 1'b0;
                        state_next.state = IETC_IDLE;
                    end
                end
                // withdraw if cleared, disabled or no longer above the cpu's level
                else if (!state_reg.req[state_reg.offerNode] || !state_reg.en[state_reg.offerNode]
                         || !(state_reg.irqLevel > cpuLevel))
                    state_next.state = IETC_IDLE;
                else if (cpuAck)
                begin
                    state_next.req[state_reg.offerNode] = 1'b0;
                    state_next.state = IETC_IDLE;
                end
            end
        endcase
        // software writes; a write to a channel overrides a same-cycle transfer
        if (apbWrite)
        begin
            if (hitNode)
            begin
                state_next.req[regIdx] = pwdata[NF_REQ];
                state_next.en[regIdx] = pwdata[NF_EN];
                state_next.level[regIdx] = pwdata[NF_LVL +: LEVEL_W];
                state_next.xferMode[regIdx] = pwdata[NF_XFER];
                state_next.chan[regIdx] = pwdata[NF_CHAN +: CHAN_W];
                state_next.altSel[regIdx] = pwdata[NF_ALT] && regIdx < IDX_W'(SHARED_COUNT);
            end
            else if (hitChan)
            begin
                unique case (paddr[3:2])
                    CH_SRC_SEL: state_next.src[chIdx] = pwdata[ADDR_W-1:0];
                    CH_DST_SEL: state_next.dst[chIdx] = pwdata[ADDR_W-1:0];
                    default:
                    begin
                        state_next.count[chIdx] = pwdata[CF_CNT +: COUNT_W];
                        state_next.cont[chIdx] = pwdata[CF_CONT];
                        state_next.incSrc[chIdx] = pwdata[CF_INCS];
                        state_next.incDst[chIdx] = pwdata[CF_INCD];
                        state_next.byteMode[chIdx] = pwdata[CF_BYTE];
                        state_next.endNode[chIdx] = pwdata[CF_END];
                    end
                endcase
            end
            else if (paddr == EDGE_OFF)
                state_next.edgeSel = pwdata[2*FAST_COUNT-1:0];
            else if (paddr == VSEG_OFF)
                state_next.vector_segment_register = pwdata[7:0];
            else if (paddr == CPUCTL_OFF)
                state_next.spacing = pwdata[1:0];
            else if (paddr == TRAP_OFF)
            begin
                state_next.trapPend = 1'b1;
                state_next.trapNum = pwdata[TRAP_W-1:0];
            end
        end
        // hardware sets win over any clear in the same cycle
        state_next.req = state_next.req | hwSet;
        if (state_reg.stealValid == 1'b0 && state_next.stealValid
            && state_reg.count[bestChan] == 8'h01 && !state_reg.cont[bestChan]
            && state_reg.endNode[bestChan])
            state_next.req[END_NODE_IDX] = 1'b1;
        else if (state_next.stealValid && state_reg.count[bestChan] == 8'h01
                 && !state_reg.cont[bestChan] && state_reg.endNode[bestChan])
            state_next.req[END_NODE_IDX] = 1'b1;
    end

    // outputs
    assign pready = 1'b1;
    assign prdata = state_reg.prdata;
    assign pslverr = state_reg.pslverr;
    assign irqReq = state_reg.state == IETC_OFFER;
    assign irqIsTrap = state_reg.offerIsTrap;
    assign irqVector = state_reg.irqVector;
    assign irqLevel = state_reg.irqLevel;
    assign irqTrapNum = state_reg.irqTrapNum;
    assign stealValid = state_reg.stealValid;
    assign stealSrc = state_reg.stealSrc;
    assign stealDst = state_reg.stealDst;
    assign stealByte = state_reg.stealByte;

    // helper copy of the counters one cycle back
    logic [CHAN_COUNT-1:0][COUNT_W-1:0] cntPast_reg;
    logic [IDX_W-1:0] swIdx;
    always_ff @(posedge clock)
    begin
        cntPast_reg <= state_reg.count;
    end
    assign swIdx = paddr[8:2];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    sequence s_trapWrite;
        psel && penable && pwrite && paddr == TRAP_OFF && state_reg.state == IETC_IDLE
        && !found && !state_reg.trapPend;
    endsequence
    sequence s_swSet;
        psel && penable && pwrite && hitNode && pwdata[NF_REQ];
    endsequence

    property p_resp;
        (state_reg.state == IETC_IDLE && found && !state_reg.trapPend)
            |=> (irqReq || stealValid);
    endproperty
    a_resp: assert property (p_resp) else $error("request not served next cycle");

    property p_steal;
        stealValid |-> !irqReq && $past(state_reg.state) == IETC_IDLE;
    endproperty
    a_steal: assert property (p_steal) else $error("stolen cycle overlaps vectoring");

    property p_inc;
        stealValid && state_reg.incSrc[state_reg.stealChan] && !$past(apbWrite)
            |-> state_reg.src[state_reg.stealChan]
                == stealSrc + (stealByte ? BYTE_STEP : WORD_STEP);
    endproperty
    a_inc: assert property (p_inc) else $error("source pointer not advanced");

    property p_count;
        stealValid && !state_reg.cont[state_reg.stealChan] && !$past(apbWrite)
            |-> state_reg.count[state_reg.stealChan]
                == cntPast_reg[state_reg.stealChan] - 8'h01;
    endproperty
    a_count: assert property (p_count) else $error("transfer count not decremented");

    property p_outrank;
        (irqReq && !irqIsTrap && !(irqLevel > cpuLevel)) |=> !irqReq;
    endproperty
    a_outrank: assert property (p_outrank) else $error("offer kept at low level");

    property p_vec;
        // the vector is built from the spacing one cycle before the offer rises
        $rose(irqReq) && !irqIsTrap && $past(state_reg.spacing) == 2'h0
            |-> irqTrapNum == TRAP_W'(FIRST_TRAP + state_reg.offerNode)
                && irqVector[15:0] == {7'h00, irqTrapNum, 2'b00};
    endproperty
    a_vec: assert property (p_vec) else $error("vector does not match node");

    property p_trap;
        s_trapWrite |-> ##2 (irqReq && irqIsTrap);
    endproperty
    a_trap: assert property (p_trap) else $error("trap not offered");

    property p_swset;
        s_swSet |=> state_reg.req[$past(swIdx)];
    endproperty
    a_swset: assert property (p_swset) else $error("software request lost");
endmodule : ietc_top

// [test/ietc_cpu_model.sv]
`timescale 1ns/1ps
// cpu stand-in: takes each offer after a set number of cycles
module ietc_cpu_model
(
    // clock
    input wire logic clock,
    // offer and accept
    input wire logic irqReq,
    input wire logic [3:0] ackWait,
    output logic cpuAck
);
    int cnt = 0;
    initial cpuAck = 1'b0;
    // ack is a one-cycle pulse so a withdrawn offer is never taken twice
    always @(posedge clock)
    begin
        cpuAck <= 1'b0;
        cnt <= (irqReq && !cpuAck) ? cnt + 1 : 0;
        if (irqReq && !cpuAck && cnt >= ackWait)
            cpuAck <= 1'b1;
    end
endmodule : ietc_cpu_model

// [test/ietc_top_tb_top.sv]
`timescale 1ns/1ps
module ietc_top_tb_top;
    import ietc_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, cpuAck, irqReq, irqIsTrap, stealValid, stealByte;
    logic [NODE_COUNT-1:0] periphReq = '0;
    logic [3:0] cpuLevel = 4'h0, fastPin = 4'h0, ackWait = 4'h2, irqLevel;
    logic [23:0] irqVector, stealSrc, stealDst;
    logic [6:0] irqTrapNum;
    logic [5:0] altReq = 6'h00;
    int failures = 0, n_tests = 0, n;
    // 250 MHz clock
    always #2 clock = ~clock;
    ietc_top dut_u (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .periphReq, .altReq, .fastPin, .cpuLevel, .cpuAck, .irqReq,
        .irqIsTrap, .irqVector, .irqLevel, .irqTrapNum, .stealValid, .stealSrc,
        .stealDst, .stealByte);
    ietc_cpu_model cpu_u (.clock, .irqReq, .ackWait, .cpuAck);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one transfer, held until pready is seen high
    task apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task pulse(input logic [NODE_COUNT-1:0] m);
        @(posedge clock);
        periphReq <= m;
        @(posedge clock);
        periphReq <= '0;
    endtask : pulse
    // bounded wait for an offer (st 0) or a stolen cycle (st 1)
    task hold(input bit st, input int lim);
        n = 0;
        while (((st ? stealValid : irqReq) !== 1'b1) && n < lim)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask : hold
    task offer(input logic [6:0] t, input logic [3:0] lv, input bit tr);
        hold(0, 12);
        chk(n <= RESP_CLK_CACHE, 1);
        chk(irqTrapNum, t);
        chk(irqVector, {8'h12, 7'h00, t, 2'b00});
        chk(irqLevel, lv);
        chk(irqIsTrap, tr);
        for (int k = 0; k < 20 && irqReq === 1'b1; k++)
            @(posedge clock);
    endtask : offer
    task give_verdict();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // watchdog
    initial
    begin
        #20000;
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        apb(1, VSEG_OFF, 32'h12);
        apb(1, 12'h014, 32'h0e);
        apb(0, 12'h014, 0);
        chk(q, 32'h0e);
        apb(0, NODE_LIMIT, 0);
        chk({err, q[30:0]}, 32'h80000000);
        pulse(96'h20);
        offer(7'h15, 4'h3, 0);
        apb(1, 12'h008, 32'h12);
        apb(1, 12'h01c, 32'h26);
        pulse(96'h84);
        offer(7'h17, 4'h9, 0);
        offer(7'h12, 4'h4, 0);
        @(posedge clock);
        cpuLevel <= 4'h9;
        ackWait <= 4'h0;
        apb(1, 12'h00c, 32'h12);
        pulse(96'h8);
        hold(0, 12);
        chk(irqReq, 0);
        @(posedge clock);
        cpuLevel <= 4'h0;
        offer(7'h13, 4'h4, 0);
        apb(1, TRAP_OFF, 32'h33);
        offer(7'h33, 4'h0, 1);
        apb(1, 12'h140, 32'h17);
        offer(7'h60, 4'h5, 0);
        apb(1, CHAN_BASE, 32'h1000);
        apb(1, 12'h204, 32'h2000);
        apb(1, 12'h208, 32'h602);
        apb(1, 12'h028, 32'h4a);
        for (int k = 0; k < 2; k++)
        begin
            pulse(96'h400);
            hold(1, 8);
            chk(stealSrc, 24'h1000 + 2 * k);
            chk(stealDst, 24'h2000 + 2 * k);
            chk({stealByte, irqReq}, 0);
            @(posedge clock);
            #1;
            chk(stealValid, 0);
        end
        offer(7'h1a, 4'h2, 0);
        apb(0, 12'h208, 0);
        chk(q, 32'h600);
        apb(1, 12'h210, 32'h3000);
        apb(1, 12'h218, 32'h1a01);
        apb(1, 12'h02c, 32'hce);
        apb(1, 12'h17c, 32'h1e);
        pulse(96'h800);
        hold(1, 8);
        chk({stealByte, stealSrc}, 32'h1003000);
        offer(7'h6f, 4'h7, 0);
        apb(0, 12'h210, 0);
        chk(q, 32'h3001);
        apb(0, 12'h02c, 0);
        chk(q, 32'hce);
        apb(1, CPUCTL_OFF, 32'h1);
        apb(1, 12'h140, 32'h17);
        hold(0, 12);
        chk(irqVector, 24'h120300);
        for (int k = 0; k < 20 && irqReq === 1'b1; k++)
            @(posedge clock);
        apb(1, CPUCTL_OFF, 32'h0);
        apb(1, EDGE_OFF, 32'h1);
        apb(1, 12'h000, 32'h41a);
        @(posedge clock);
        fastPin <= 4'h1;
        offer(7'h10, 4'h6, 0);
        @(posedge clock);
        fastPin <= 4'h0;
        hold(0, 12);
        chk(irqReq, 0);
        give_verdict();
    end
endmodule : ietc_top_tb_top
